// ===== mol_pkg.sv
// Constants shared by the mask-option latch control block.
package mol_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int OPT_W = 3;

	localparam logic [11:0] OFS_DDR_A = 12'h004;
	localparam logic [11:0] OFS_DDR_B = 12'h005;
	localparam logic [11:0] OFS_PROG_CTRL = 12'h01c;
	localparam logic [11:0] OFS_ADC_CTRL = 12'h01e;
	localparam logic [11:0] OFS_WDOG_CTRL = 12'h01f;
	localparam logic [11:0] OFS_WDOG_SERVICE = 12'h020;
	localparam logic [11:0] OFS_STATUS = 12'h021;
	localparam logic [11:0] OFS_OPT = 12'h900;

	localparam int OPT_WDOG_EN_BIT = 0;
	localparam int OPT_IRQ_LEVEL_BIT = 1;
	localparam int OPT_LSB_FIRST_BIT = 2;
	localparam int VIEW_SEL_BIT = 2;
	localparam int ADC_ON_BIT = 7;
	localparam int STAT_WDOG_RST_BIT = 0;
	localparam int STAT_WDOG_RUN_BIT = 1;
	localparam int STAT_BOOT_BIT = 2;

	localparam logic [7:0] PROG_CTRL_RST = 8'h00;
	localparam logic [7:0] WDOG_CTRL_RST = 8'h00;
	localparam logic [7:0] ADC_CTRL_RST = 8'h00;
	localparam logic [7:0] DDR_RST = 8'h00;
	localparam logic [2:0] OPT_LATCH_RST = 3'h0;
	// Synchroniser reset: interrupt pin idle high, part and option pins low.
	localparam logic [4:0] PIN_SYNC_RST = 5'h08;
	localparam logic [7:0] WDOG_ENABLE_CODE = 8'h04;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// Two synchroniser stages plus one load cycle after reset release.
	localparam logic [1:0] BOOT_LOAD_CYCLES = 2'h3;

	localparam int CLK_PERIOD_NS = 10;
	localparam int WDOG_TIMEOUT_NS = 655360;
	localparam int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int WDOG_CNT_W = 17;

endpackage

// ===== mol_ctl_if.sv
// Internal carrier between the control top, the option store and the watchdog.
`timescale 1ns/10ps
interface mol_ctl_if;
	logic opt_wr;
	logic [7:0] opt_wdata;
	logic reload;
	logic [2:0] prog_opt;
	logic view_sel;
	logic [2:0] latch;
	logic [7:0] opt_rdata;
	logic wd_run;
	logic wd_service;
	logic wd_clear;
	logic wd_timeout;

	modport store (
		input opt_wr, opt_wdata, reload, prog_opt, view_sel,
		output latch, opt_rdata
	);
	modport dog (
		input wd_run, wd_service, wd_clear,
		output wd_timeout
	);
	modport ctl (
		output opt_wr, opt_wdata, reload, prog_opt, view_sel, wd_run, wd_service, wd_clear,
		input latch, opt_rdata, wd_timeout
	);
endinterface

// ===== mol_option_store.sv
// Programmed option copy and the writable option latch sharing one address.
`timescale 1ns/10ps
module mol_option_store (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	mol_ctl_if.store bus
);

	logic [2:0] latch_r;
	logic [2:0] latch_nxt;
	logic [2:0] view_data;

	assign latch_nxt = bus.reload ? bus.prog_opt : // RL5
		((bus.opt_wr && !bus.view_sel) ? bus.opt_wdata[2:0] : latch_r); // RL4 RL7 RL8

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			latch_r <= mol_pkg::OPT_LATCH_RST;
		end else if (ce_in) begin
			latch_r <= latch_nxt;
		end
	end

	assign view_data = bus.view_sel ? latch_r : bus.prog_opt; // RL7 RL8
	assign bus.opt_rdata = {5'h00, view_data}; // RL13
	assign bus.latch = latch_r;

endmodule

// ===== mol_watchdog.sv
// Liveness watchdog counter that pulses on timeout unless serviced.
`timescale 1ns/10ps
module mol_watchdog #(
	parameter int TIMEOUT_CYCLES = mol_pkg::WDOG_TIMEOUT_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	mol_ctl_if.dog bus
);

	localparam logic [16:0] LAST = 17'(TIMEOUT_CYCLES - 1);

	logic [16:0] cnt_r;
	logic [16:0] cnt_nxt;
	logic tmo_r;
	logic expire;

	assign expire = bus.wd_run && !bus.wd_service && (cnt_r == LAST);
	assign cnt_nxt = (bus.wd_clear || !bus.wd_run || bus.wd_service || expire) ? 17'h00000 :
		cnt_r + 17'h00001;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= 17'h00000;
			tmo_r <= 1'b0;
		end else if (ce_in) begin
			cnt_r <= cnt_nxt;
			tmo_r <= expire && !bus.wd_clear;
		end
	end

	assign bus.wd_timeout = tmo_r;

endmodule

// ===== mol_top.sv
// Mask-option latch control: option registers, watchdog gating and reset effects.
// Functional notes
// RL1 - Option bit 2 selects serial LSB-first order.
// RL2 - Option bit 1 adds low-level interrupt sensing.
// RL3 - Option bit 0 enables the watchdog.
// RL4 - Fixed programmed copy, writable latch controls.
// RL5 - Every reset reloads latch from programmed copy.
// RL6 - View select is program control bit 2.
// RL7 - View 0: read programmed, write latch.
// RL8 - View 1: read latch, writes ignored.
// RL9 - Watchdog reset keeps port directions.
// RL10 - Alternate part: writing 4 enables watchdog.
// RL11 - Programmed watchdog plus low interrupt runs watchdog.
// RL12 - Reset turns converter off; write re-enables.
// RL13 - Option bits 7..3 read zero.
`timescale 1ns/10ps
module mol_top #(
	parameter int WDOG_TIMEOUT_CYCLES = mol_pkg::WDOG_TIMEOUT_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [11:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_stb_in,
	input wire logic rd_stb_in,
	output logic [7:0] rd_data_out,
	input wire logic [2:0] prog_opt_in,
	input wire logic irq_n_in,
	input wire logic alt_part_in,
	output logic lsb_first_out,
	output logic irq_level_out,
	output logic wdog_running_out,
	output logic wdog_reset_out,
	output logic adc_on_out,
	output logic [7:0] ddr_a_out,
	output logic [7:0] ddr_b_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	localparam int PIN_W = 5;

	logic [4:0] pin_raw;
	logic [4:0] pin_meta_r;
	logic [4:0] pin_sync_r;
	logic [2:0] prog_sync;
	logic irq_n_sync;
	logic alt_sync;

	assign pin_raw = {alt_part_in, irq_n_in, prog_opt_in};

	// Only the second stage is read, so a metastable first stage never reaches the logic.
	for (genvar g = 0; g < PIN_W; g++) begin : g_pin_sync
		always_ff @(posedge core_clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				pin_meta_r[g] <= mol_pkg::PIN_SYNC_RST[g];
				pin_sync_r[g] <= mol_pkg::PIN_SYNC_RST[g];
			end else if (ce_in) begin
				pin_meta_r[g] <= pin_raw[g];
				pin_sync_r[g] <= pin_meta_r[g];
			end
		end
	end

	assign prog_sync = pin_sync_r[2:0];
	assign irq_n_sync = pin_sync_r[3];
	assign alt_sync = pin_sync_r[4];

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	logic hit_prog;
	logic hit_adc;
	logic hit_wdog;
	logic hit_svc;
	logic hit_stat;
	logic hit_opt;
	logic hit_ddr_a;
	logic hit_ddr_b;
	logic hit_any;

	// Every register has a full-width compare; an unmapped address reads as zero.
	assign hit_prog = (addr_in == mol_pkg::OFS_PROG_CTRL);
	assign hit_adc = (addr_in == mol_pkg::OFS_ADC_CTRL);
	assign hit_wdog = (addr_in == mol_pkg::OFS_WDOG_CTRL);
	assign hit_svc = (addr_in == mol_pkg::OFS_WDOG_SERVICE);
	assign hit_stat = (addr_in == mol_pkg::OFS_STATUS);
	assign hit_opt = (addr_in == mol_pkg::OFS_OPT);
	assign hit_ddr_a = (addr_in == mol_pkg::OFS_DDR_A);
	assign hit_ddr_b = (addr_in == mol_pkg::OFS_DDR_B);
	assign hit_any = hit_prog | hit_adc | hit_wdog | hit_svc | hit_stat | hit_opt |
		hit_ddr_a | hit_ddr_b;

	////////////////////////////////////////////////////////////////////////////////
	// Sub-blocks.

	// The option store and the watchdog share one carrier with the control logic.
	mol_ctl_if ctl ();

	mol_option_store u_store (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.bus(ctl.store)
	);

	mol_watchdog #(
		.TIMEOUT_CYCLES(WDOG_TIMEOUT_CYCLES)
	) u_dog (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.bus(ctl.dog)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Reset sequencing.

	logic [1:0] boot_cnt_r;
	logic boot_busy;
	logic wd_rst;

	// A watchdog reset is internal: it re-runs the soft state but never the port directions.
	assign wd_rst = ctl.wd_timeout;
	assign boot_busy = (boot_cnt_r != 2'h0);

	// The boot count keeps option writes and the watchdog off until the synchronised
	// programmed copy has reached the latch.

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boot_cnt_r <= mol_pkg::BOOT_LOAD_CYCLES;
		end else if (ce_in && boot_busy) begin
			boot_cnt_r <= boot_cnt_r - 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers.

	logic [7:0] prog_ctrl_r;
	logic [7:0] prog_ctrl_nxt;
	logic [7:0] adc_ctrl_r;
	logic [7:0] adc_ctrl_nxt;
	logic [7:0] wdog_ctrl_r;
	logic [7:0] wdog_ctrl_nxt;
	logic wdog_sw_en_r;
	logic wdog_sw_en_nxt;
	logic wdog_rst_flag_r;
	logic wd_flag_nxt;
	logic [7:0] ddr_a_r;
	logic [7:0] ddr_a_nxt;
	logic [7:0] ddr_b_r;
	logic [7:0] ddr_b_nxt;
	logic wr_prog;
	logic wr_adc;
	logic wr_wdog;
	logic wr_stat;
	logic wr_ddr_a;
	logic wr_ddr_b;
	logic sw_enable;

	assign wr_prog = wr_stb_in && hit_prog;
	assign wr_adc = wr_stb_in && hit_adc;
	assign wr_wdog = wr_stb_in && hit_wdog;
	assign wr_stat = wr_stb_in && hit_stat;
	assign wr_ddr_a = wr_stb_in && hit_ddr_a;
	assign wr_ddr_b = wr_stb_in && hit_ddr_b;
	assign sw_enable = wr_wdog && alt_sync && (wr_data_in == mol_pkg::WDOG_ENABLE_CODE); // RL10

	// A watchdog reset returns the soft registers to their reset values and wins over a
	// write in the same cycle, because the software is restarted anyway.
	assign prog_ctrl_nxt = wd_rst ? mol_pkg::PROG_CTRL_RST :
		(wr_prog ? wr_data_in : prog_ctrl_r);
	assign adc_ctrl_nxt = wd_rst ? mol_pkg::ADC_CTRL_RST : // RL12
		(wr_adc ? wr_data_in : adc_ctrl_r); // RL12
	assign wdog_ctrl_nxt = wd_rst ? mol_pkg::WDOG_CTRL_RST :
		(wr_wdog ? wr_data_in : wdog_ctrl_r);
	assign wdog_sw_en_nxt = !wd_rst && (sw_enable || wdog_sw_en_r); // RL10
	// The flag is set by hardware and cleared by writing one; a set in the same cycle
	// as the clear wins, so that no watchdog reset goes unreported.
	assign wd_flag_nxt = wd_rst ? 1'b1 :
		((wr_stat && wr_data_in[mol_pkg::STAT_WDOG_RST_BIT]) ? 1'b0 : wdog_rst_flag_r);
	// Port directions answer only the external reset, never the watchdog one.
	assign ddr_a_nxt = wr_ddr_a ? wr_data_in : ddr_a_r; // RL9
	assign ddr_b_nxt = wr_ddr_b ? wr_data_in : ddr_b_r; // RL9

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prog_ctrl_r <= mol_pkg::PROG_CTRL_RST; // RL6
		end else if (ce_in) begin
			prog_ctrl_r <= prog_ctrl_nxt;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			adc_ctrl_r <= mol_pkg::ADC_CTRL_RST; // RL12
		end else if (ce_in) begin
			adc_ctrl_r <= adc_ctrl_nxt;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wdog_ctrl_r <= mol_pkg::WDOG_CTRL_RST;
		end else if (ce_in) begin
			wdog_ctrl_r <= wdog_ctrl_nxt;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wdog_sw_en_r <= 1'b0;
		end else if (ce_in) begin
			wdog_sw_en_r <= wdog_sw_en_nxt;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wdog_rst_flag_r <= 1'b0;
		end else if (ce_in) begin
			wdog_rst_flag_r <= wd_flag_nxt;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ddr_a_r <= mol_pkg::DDR_RST; // RL9
		end else if (ce_in) begin
			ddr_a_r <= ddr_a_nxt;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ddr_b_r <= mol_pkg::DDR_RST; // RL9
		end else if (ce_in) begin
			ddr_b_r <= ddr_b_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Option store and watchdog hookup.

	logic view_sel;
	logic wd_run;

	assign view_sel = prog_ctrl_r[mol_pkg::VIEW_SEL_BIT]; // RL6
	assign ctl.view_sel = view_sel;
	assign ctl.opt_wr = wr_stb_in && hit_opt && !boot_busy; // RL7 RL8
	assign ctl.opt_wdata = wr_data_in;
	assign ctl.prog_opt = prog_sync;
	assign ctl.reload = boot_busy || wd_rst; // RL5

	// The programmed watchdog bit with a low interrupt pin runs the watchdog even when
	// software never enabled it.
	assign wd_run = ctl.latch[mol_pkg::OPT_WDOG_EN_BIT] || wdog_sw_en_r || // RL3
		(prog_sync[mol_pkg::OPT_WDOG_EN_BIT] && !irq_n_sync); // RL11
	assign ctl.wd_run = wd_run && !boot_busy;
	assign ctl.wd_service = wr_stb_in && hit_svc;
	assign ctl.wd_clear = boot_busy;

	////////////////////////////////////////////////////////////////////////////////
	// Read path.

	logic [7:0] stat_val;
	logic [7:0] rd_mux;
	logic [7:0] rd_data_r;

	assign stat_val = {5'h00, !boot_busy, ctl.wd_run, wdog_rst_flag_r};
	assign rd_mux = ({8{hit_prog}} & prog_ctrl_r) |
		({8{hit_adc}} & adc_ctrl_r) |
		({8{hit_wdog}} & wdog_ctrl_r) |
		({8{hit_stat}} & stat_val) |
		({8{hit_opt}} & ctl.opt_rdata) | // RL13
		({8{hit_ddr_a}} & ddr_a_r) |
		({8{hit_ddr_b}} & ddr_b_r) |
		({8{!hit_any}} & mol_pkg::RD_UNMAPPED);

	// Read data stand only in the cycle after the strobe and are zero otherwise, so an
	// idle bus shows a quiet value.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_r <= 8'h00;
		end else if (ce_in) begin
			rd_data_r <= rd_stb_in ? rd_mux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign rd_data_out = rd_data_r;
	assign lsb_first_out = ctl.latch[mol_pkg::OPT_LSB_FIRST_BIT]; // RL1
	assign irq_level_out = ctl.latch[mol_pkg::OPT_IRQ_LEVEL_BIT]; // RL2
	assign wdog_running_out = ctl.wd_run;
	assign wdog_reset_out = wd_rst;
	assign adc_on_out = adc_ctrl_r[mol_pkg::ADC_ON_BIT]; // RL12
	assign ddr_a_out = ddr_a_r;
	assign ddr_b_out = ddr_b_r;

endmodule

// ===== mol_top_sva.sv
// Concurrent assertions on the ports of the mask-option latch control top.
`timescale 1ns/10ps
module mol_top_sva #(
	parameter int WDOG_TIMEOUT_CYCLES = mol_pkg::WDOG_TIMEOUT_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [11:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_stb_in,
	input wire logic rd_stb_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [2:0] prog_opt_in,
	input wire logic alt_part_in,
	input wire logic wdog_running_out,
	input wire logic wdog_reset_out,
	input wire logic adc_on_out,
	input wire logic [7:0] ddr_a_out,
	input wire logic [7:0] ddr_b_out
);
	localparam int LO = WDOG_TIMEOUT_CYCLES - 1;
	localparam int HI = WDOG_TIMEOUT_CYCLES + 3;
	logic view_r;
	logic [31:0] run_cnt_r;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////////////////////////////////////////
	// Shadow of the view select and a count of unserviced running cycles.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			view_r <= 1'b0;
			run_cnt_r <= 32'h0;
		end else begin
			if (wdog_reset_out) begin
				view_r <= 1'b0;
			end else if (wr_stb_in && addr_in == mol_pkg::OFS_PROG_CTRL) begin
				view_r <= wr_data_in[mol_pkg::VIEW_SEL_BIT];
			end
			if (!wdog_running_out || wdog_reset_out
				|| (wr_stb_in && addr_in == mol_pkg::OFS_WDOG_SERVICE)) begin
				run_cnt_r <= 32'h0;
			end else begin
				run_cnt_r <= run_cnt_r + 32'h1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	sequence opt_rd_s;
		rd_stb_in && addr_in == mol_pkg::OFS_OPT;
	endsequence
	chk_rd_idle_zero: assert property (!$past(rd_stb_in) |-> rd_data_out == 8'h00)
		else $error("read data not zero outside read cycle");
	chk_opt_high_zero: assert property (opt_rd_s |=> rd_data_out[7:3] == 5'h00)
		else $error("option high bits not zero");
	chk_opt_prog_view: assert property (opt_rd_s ##0 !view_r |=>
		rd_data_out[2:0] == $past(prog_opt_in, 3)) else $error("view 0 read not programmed copy");
	chk_wd_keeps_ddr: assert property (wdog_reset_out |=>
		$stable(ddr_a_out) && $stable(ddr_b_out)) else $error("watchdog reset changed ddr");
	chk_wd_adc_off: assert property (wdog_reset_out |=> !adc_on_out)
		else $error("converter on after watchdog reset");
	chk_wd_pulse_one: assert property (wdog_reset_out |=> !wdog_reset_out)
		else $error("watchdog reset pulse too long");
	chk_wd_fire_time: assert property ($rose(wdog_reset_out) |->
		run_cnt_r >= LO && run_cnt_r <= HI) else $error("watchdog fired at wrong count");
	chk_wd_must_fire: assert property (run_cnt_r <= HI)
		else $error("watchdog did not fire");
	chk_alt_enable_run: assert property (wr_stb_in && addr_in == mol_pkg::OFS_WDOG_CTRL
		&& wr_data_in == mol_pkg::WDOG_ENABLE_CODE && alt_part_in |-> ##[1:2] wdog_running_out)
		else $error("write 4 did not start watchdog");
endmodule

// ===== mol_top_test.sv
// Self-checking bench for the mask-option latch control top.
`timescale 1ns/10ps
module mol_top_test;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic [11:0] addr_in = 12'h000;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_stb_in = 1'b0;
	logic rd_stb_in = 1'b0;
	logic [2:0] prog_opt_in = 3'h6;
	logic irq_n_in = 1'b1;
	logic alt_part_in = 1'b0;
	logic [7:0] rd_data_out, ddr_a_out, ddr_b_out;
	logic lsb_first_out, irq_level_out, wdog_running_out, wdog_reset_out, adc_on_out;
	int failures = 0;
	int total_checks = 0;
	int pulses = 0;

	always #5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) if (wdog_reset_out === 1'b1) pulses <= pulses + 1;

	mol_top #(.WDOG_TIMEOUT_CYCLES(16)) i_mol_top (.core_clk_in, .rst_n_in, .ce_in,
		.addr_in, .wr_data_in, .wr_stb_in, .rd_stb_in, .rd_data_out, .prog_opt_in, .irq_n_in,
		.alt_part_in, .lsb_first_out, .irq_level_out, .wdog_running_out, .wdog_reset_out,
		.adc_on_out, .ddr_a_out, .ddr_b_out);
	////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_stb_in <= 1'b1;
		@(posedge core_clk_in);
		wr_stb_in <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_stb_in <= 1'b1;
		@(posedge core_clk_in);
		rd_stb_in <= 1'b0;
		#1;
		chk(name, exp, rd_data_out);
	endtask
	task automatic do_reset();
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		repeat (16) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		tick(20);
	endtask
	task automatic wpulse();
		int n;
		n = pulses;
		for (int i = 0; i < 40 && pulses == n; i++) tick(1);
		chk("wdog pulse", 8'h01, 8'(pulses != n));
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		int p;
		do_reset();
		chk("lsb first", 8'h01, lsb_first_out);
		chk("irq level", 8'h01, irq_level_out);
		chk("running", 8'h00, wdog_running_out);
		chk("adc on", 8'h00, adc_on_out);
		rd(mol_pkg::OFS_OPT, 8'h06, "opt view0");
		rd(mol_pkg::OFS_PROG_CTRL, 8'h00, "prog ctrl");
		rd(12'h3ff, 8'h00, "unmapped");
		@(posedge core_clk_in);
		ce_in <= 1'b0;
		wr(mol_pkg::OFS_DDR_A, 8'h33);
		@(posedge core_clk_in);
		ce_in <= 1'b1;
		tick(1);
		chk("ce frozen ddr", 8'h00, ddr_a_out);
		$display("test reset state done");
		wr(mol_pkg::OFS_OPT, 8'hfa);
		tick(1);
		chk("lsb first", 8'h00, lsb_first_out);
		chk("irq level", 8'h01, irq_level_out);
		chk("running", 8'h00, wdog_running_out);
		rd(mol_pkg::OFS_OPT, 8'h06, "opt programmed");
		wr(mol_pkg::OFS_PROG_CTRL, 8'h04);
		rd(mol_pkg::OFS_OPT, 8'h02, "opt view1");
		wr(mol_pkg::OFS_OPT, 8'h05);
		rd(mol_pkg::OFS_OPT, 8'h02, "opt view1 write");
		wr(mol_pkg::OFS_PROG_CTRL, 8'h00);
		rd(mol_pkg::OFS_OPT, 8'h06, "opt back view0");
		$display("test option views done");
		wr(mol_pkg::OFS_DDR_A, 8'h5a);
		wr(mol_pkg::OFS_DDR_B, 8'ha5);
		wr(mol_pkg::OFS_ADC_CTRL, 8'h80);
		tick(1);
		chk("adc on", 8'h01, adc_on_out);
		rd(mol_pkg::OFS_ADC_CTRL, 8'h80, "adc ctrl");
		wr(mol_pkg::OFS_OPT, 8'h01);
		tick(1);
		chk("running", 8'h01, wdog_running_out);
		chk("irq edge only", 8'h00, irq_level_out);
		wr(mol_pkg::OFS_PROG_CTRL, 8'h04);
		p = pulses;
		repeat (4) begin
			wr(mol_pkg::OFS_WDOG_SERVICE, 8'h00);
			tick(6);
		end
		chk("serviced", 8'(p), 8'(pulses));
		wpulse();
		tick(2);
		chk("ddr a kept", 8'h5a, ddr_a_out);
		chk("ddr b kept", 8'ha5, ddr_b_out);
		chk("adc off", 8'h00, adc_on_out);
		chk("lsb reload", 8'h01, lsb_first_out);
		chk("running", 8'h00, wdog_running_out);
		rd(mol_pkg::OFS_PROG_CTRL, 8'h00, "prog ctrl wd cleared");
		rd(mol_pkg::OFS_OPT, 8'h06, "opt after wd reset");
		rd(mol_pkg::OFS_DDR_A, 8'h5a, "ddr a read");
		rd(mol_pkg::OFS_STATUS, 8'h05, "status wd flag");
		wr(mol_pkg::OFS_STATUS, 8'h01);
		rd(mol_pkg::OFS_STATUS, 8'h04, "status cleared");
		$display("test latch watchdog done");
		@(posedge core_clk_in);
		prog_opt_in <= 3'h1;
		irq_n_in <= 1'b0;
		tick(5);
		chk("running irq low", 8'h01, wdog_running_out);
		wpulse();
		@(posedge core_clk_in);
		prog_opt_in <= 3'h0;
		irq_n_in <= 1'b1;
		do_reset();
		chk("ddr a cleared", 8'h00, ddr_a_out);
		chk("ddr b cleared", 8'h00, ddr_b_out);
		chk("running", 8'h00, wdog_running_out);
		$display("test programmed watchdog done");
		wr(mol_pkg::OFS_WDOG_CTRL, 8'h04);
		tick(1);
		chk("no alt part", 8'h00, wdog_running_out);
		@(posedge core_clk_in);
		alt_part_in <= 1'b1;
		tick(5);
		wr(mol_pkg::OFS_WDOG_CTRL, 8'h03);
		tick(1);
		chk("alt code 3", 8'h00, wdog_running_out);
		wr(mol_pkg::OFS_WDOG_CTRL, 8'h04);
		tick(1);
		chk("alt code 4", 8'h01, wdog_running_out);
		wpulse();
		$display("test alternate enable done");
		summarize();
	end
	// The sequence needs well under 2000 cycles; this bound only catches a hang.
	initial begin
		#50000;
		failures++;
		summarize();
	end
endmodule
bind mol_top mol_top_sva #(.WDOG_TIMEOUT_CYCLES(WDOG_TIMEOUT_CYCLES)) i_mol_top_sva (
	.core_clk_in, .rst_n_in, .addr_in, .wr_data_in, .wr_stb_in, .rd_stb_in, .rd_data_out,
	.prog_opt_in, .alt_part_in, .wdog_running_out, .wdog_reset_out, .adc_on_out,
	.ddr_a_out, .ddr_b_out);
